// ---- boot_pkg.sv ----
package boot_pkg;

   // ---------------------------------------------------------------
   // addresses
   // ---------------------------------------------------------------
   localparam logic [16:0] SETUP_BYTE_ADDR  = 17'h02018;
   localparam logic [16:0] FIRST_FETCH_ADDR = 17'h02080;
   localparam logic [16:0] LOW_VEC_BASE     = 17'h02000;
   localparam logic [16:0] HIGH_VEC_BASE    = 17'h02030;
   localparam logic [16:0] TS_VEC_BASE      = 17'h02040;
   localparam logic [16:0] TRAP_SW_VEC      = 17'h02010;
   localparam logic [16:0] TRAP_OPC_VEC     = 17'h02012;
   localparam logic [16:0] SFR_LAST         = 17'h00019;
   localparam logic [16:0] RAM_LAST         = 17'h003ff;
   localparam logic [16:0] RSV_LO_FIRST     = 17'h02000;
   localparam logic [16:0] RSV_LO_LAST      = 17'h0207f;

   // ---------------------------------------------------------------
   // setup field positions
   // ---------------------------------------------------------------
   localparam int SETUP_PD_BIT    = 0;
   localparam int SETUP_DYN_BIT   = 1;
   localparam int SETUP_WR_BIT    = 2;
   localparam int SETUP_ADV_BIT   = 3;
   localparam int SETUP_RDY_LO    = 4;
   localparam int SETUP_RDY_HI    = 5;
   localparam logic [7:0] SETUP_RESET = 8'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          RESET_PULL_STATES = 16;
   localparam logic [4:0]  RESET_PULL_CYCLES = 5'(RESET_PULL_STATES);
   localparam logic [15:0] NMI_VEC_NUM       = 16'h000f;

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_SETUP   = 4'h0;
   localparam logic [3:0] OFS_STATUS  = 4'h4;
   localparam logic [3:0] OFS_VECTOR  = 4'h8;
   localparam logic [3:0] OFS_DECODE  = 4'hc;

   typedef enum logic [1:0] {
      REGION_SFR  = 2'h0,
      REGION_RAM  = 2'h1,
      REGION_EXT  = 2'h2,
      REGION_RSV  = 2'h3
   } region_type;

   typedef struct packed {
      logic [1:0] ready_mode;
      logic       adv_mode;
      logic       split_wr;
      logic       dyn_width;
      logic       pd_enable;
   } setup_fields_type;

   typedef struct packed {
      logic        req;
      logic [16:0] addr;
      logic        wide;
   } mem_req_type;

endpackage

// ---- reset_config_and_vector_map.sv ----
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - after reset, read setup byte at 2018H
// - fetch width follows sampled width pin
// - setup bits 7 and 6 ignored
// - bits 5:4 select ready wait limit
// - bit 3 picks latch or valid strobe
// - bit 2 picks write strobe style
// - bit 0 enables power-down, else ignored
// - bit 1 low forces 8-bit bus
// - bit 1 high: width pin decides width
// - device pulls reset low 16 states
// - first fetch from 2080h
// - external memory serves code and data
// - prioritized and trap vector addresses
// - priority equals number, 15 highest
// - traps bypass prioritization, serviced at once
// - server interrupts beat other maskable ones
module reset_config_and_vector_map
(
   input  wire logic                          clk,
   input  wire logic                          srst,
   // reset pin as open drain
   input  wire logic                          reset_pin_in,
   output logic                               reset_pin_out,
   output logic                               reset_pin_oe,
   input  wire logic                          width_select_pin,
   // setup byte fetch on the external bus
   output boot_pkg::mem_req_type              fetch_req,
   input  wire logic                          fetch_ack,
   input  wire logic [15:0]                   fetch_data,
   output logic                               boot_done,
   output logic [16:0]                        first_fetch_addr,
   // decoded setup
   output logic                               ready_limit_hi,
   output logic                               ready_limit_lo,
   output logic                               addr_strobe_is_valid,
   output logic                               split_write_strobes,
   output logic                               bus_wide,
   input  wire logic                          pd_request,
   output logic                               pd_grant,
   // vector lookup
   input  wire logic [15:0]                   irq_pending,
   input  wire logic [15:0]                   irq_to_server,
   input  wire logic                          trap_opcode,
   input  wire logic                          trap_software,
   output logic                               vec_valid,
   output logic [16:0]                        vec_addr,
   output logic                               vec_server,
   output logic [3:0]                         vec_priority,
   // address region decode
   input  wire logic [16:0]                   decode_addr,
   output boot_pkg::region_type               decode_region,
   // Avalon-MM slave
   input  wire logic [3:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic [31:0]                        avs_readdata,
   output logic                               avs_waitrequest
);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [16:0] prio_vec(input logic [3:0] num);
      logic [16:0] v;
      v = num[3] ? boot_pkg::HIGH_VEC_BASE + 17'({num[2:0], 1'b0})
                 : boot_pkg::LOW_VEC_BASE + 17'({num[2:0], 1'b0});
      return v;
   endfunction

   function automatic logic [16:0] server_vec(input logic [3:0] num);
      logic [16:0] v;
      v = boot_pkg::TS_VEC_BASE + 17'({num, 1'b0});
      return v;
   endfunction

   function automatic boot_pkg::region_type region_of(input logic [16:0] a);
      boot_pkg::region_type r;
      if (a <= boot_pkg::SFR_LAST)
         r = boot_pkg::REGION_SFR;
      else if (a <= boot_pkg::RAM_LAST)
         r = boot_pkg::REGION_RAM;
      else if (a >= boot_pkg::RSV_LO_FIRST && a <= boot_pkg::RSV_LO_LAST)
         r = boot_pkg::REGION_RSV;
      else
         r = boot_pkg::REGION_EXT;
      return r;
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] rst_sync_reg;
   logic [2:0] width_sync_reg;
   logic       rst_low_reg;
   logic       width_reg;

   always_ff @(posedge clk)
   begin
      rst_sync_reg   <= {rst_sync_reg[1:0], reset_pin_in};
      width_sync_reg <= {width_sync_reg[1:0], width_select_pin};
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rst_low_reg <= 1'b0;
         width_reg   <= 1'b0;
      end
      else
      begin
         if (rst_sync_reg[1] == rst_sync_reg[2])
            rst_low_reg <= ~rst_sync_reg[2];
         if (width_sync_reg[1] == width_sync_reg[2])
            width_reg <= width_sync_reg[2];
      end
   end

   // ---------------------------------------------------------------
   // boot sequence
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_HOLD  = 4'b0001,
      ST_PULL  = 4'b0010,
      ST_FETCH = 4'b0100,
      ST_RUN   = 4'b1000
   } boot_state_type;

   boot_state_type state_reg;
   boot_state_type state_next;
   logic [4:0]     pull_cnt_reg;
   logic [7:0]     setup_reg;
   logic           fetch_wide_reg;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_HOLD:  if (!rst_low_reg) state_next = ST_FETCH;
         ST_PULL:  if (pull_cnt_reg == 5'h00 && !rst_low_reg) state_next = ST_FETCH;
         ST_FETCH: if (fetch_ack) state_next = ST_RUN;
         ST_RUN:   state_next = ST_RUN;
      endcase
      if (rst_low_reg && state_reg != ST_PULL && state_reg != ST_HOLD)
         state_next = ST_PULL;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         state_reg <= ST_PULL;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         pull_cnt_reg <= boot_pkg::RESET_PULL_CYCLES;
      else if (state_next == ST_PULL && state_reg != ST_PULL)
         pull_cnt_reg <= boot_pkg::RESET_PULL_CYCLES;
      else if (state_reg == ST_PULL && pull_cnt_reg != 5'h00)
         pull_cnt_reg <= pull_cnt_reg - 5'h01;
   end

   // open drain: drive low only, oe low while driving
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe  = ~(state_reg == ST_PULL && pull_cnt_reg != 5'h00);

   always_ff @(posedge clk)
   begin
      if (srst)
         fetch_wide_reg <= 1'b0;
      else if (state_reg != ST_FETCH)
         fetch_wide_reg <= width_reg;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         setup_reg <= boot_pkg::SETUP_RESET;
      else if (state_next == ST_PULL)
         setup_reg <= boot_pkg::SETUP_RESET;
      else if (state_reg == ST_FETCH && fetch_ack)
         setup_reg <= fetch_data[7:0];
   end

   assign fetch_req.req  = (state_reg == ST_FETCH);
   assign fetch_req.addr = boot_pkg::SETUP_BYTE_ADDR;
   assign fetch_req.wide = fetch_wide_reg;

   assign boot_done        = (state_reg == ST_RUN);
   assign first_fetch_addr = boot_pkg::FIRST_FETCH_ADDR;

   // ---------------------------------------------------------------
   // setup decode (bits 7:6 unused)
   // ---------------------------------------------------------------
   boot_pkg::setup_fields_type setup_f;

   assign setup_f.ready_mode = setup_reg[boot_pkg::SETUP_RDY_HI:boot_pkg::SETUP_RDY_LO];
   assign setup_f.adv_mode   = setup_reg[boot_pkg::SETUP_ADV_BIT];
   assign setup_f.split_wr   = setup_reg[boot_pkg::SETUP_WR_BIT];
   assign setup_f.dyn_width  = setup_reg[boot_pkg::SETUP_DYN_BIT];
   assign setup_f.pd_enable  = setup_reg[boot_pkg::SETUP_PD_BIT];

   assign ready_limit_hi       = setup_f.ready_mode[1];
   assign ready_limit_lo       = setup_f.ready_mode[0];
   assign addr_strobe_is_valid = setup_f.adv_mode;
   assign split_write_strobes  = setup_f.split_wr;
   assign bus_wide             = setup_f.dyn_width & width_reg;
   assign pd_grant             = boot_done & pd_request & setup_f.pd_enable;

   // ---------------------------------------------------------------
   // vector selection
   // ---------------------------------------------------------------
   logic [16:0] vec_next;
   logic        server_next;
   logic [3:0]  prio_next;
   logic        valid_next;

   always_comb
   begin
      vec_next    = '0;
      server_next = 1'b0;
      prio_next   = 4'h0;
      valid_next  = 1'b0;
      // maskable ranked by number, lowest first so higher overrides
      for (int i = 0; i < 15; i++)
         if (irq_pending[i])
         begin
            vec_next   = prio_vec(4'(i));
            prio_next  = 4'(i);
            valid_next = 1'b1;
         end
      for (int i = 0; i < 15; i++)
         if (irq_pending[i] && irq_to_server[i])
         begin
            vec_next    = server_vec(4'(i));
            prio_next   = 4'(i);
            server_next = 1'b1;
         end
      if (irq_pending[15])
      begin
         vec_next    = prio_vec(boot_pkg::NMI_VEC_NUM[3:0]);
         prio_next   = boot_pkg::NMI_VEC_NUM[3:0];
         server_next = 1'b0;
         valid_next  = 1'b1;
      end
      if (trap_software)
      begin
         vec_next    = boot_pkg::TRAP_SW_VEC;
         server_next = 1'b0;
         valid_next  = 1'b1;
      end
      if (trap_opcode)
      begin
         vec_next    = boot_pkg::TRAP_OPC_VEC;
         server_next = 1'b0;
         valid_next  = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         vec_addr     <= '0;
         vec_server   <= 1'b0;
         vec_priority <= 4'h0;
         vec_valid    <= 1'b0;
      end
      else
      begin
         vec_addr     <= vec_next;
         vec_server   <= server_next;
         vec_priority <= prio_next;
         vec_valid    <= valid_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         decode_region <= boot_pkg::REGION_SFR;
      else
         decode_region <= region_of(decode_addr);
   end

   // ---------------------------------------------------------------
   // register bus: one wait cycle, then answer
   // ---------------------------------------------------------------
   logic ack_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

   // setup register is read only; writes are ignored
   always_ff @(posedge clk)
   begin
      if (srst)
         avs_readdata <= '0;
      else if (avs_read && !ack_reg)
      begin
         unique case (avs_address)
            boot_pkg::OFS_SETUP:  avs_readdata <= {24'h000000, setup_reg};
            boot_pkg::OFS_STATUS: avs_readdata <= {26'h0, bus_wide, width_reg,
                                                    state_reg};
            boot_pkg::OFS_VECTOR: avs_readdata <= {10'h000, vec_valid, vec_server,
                                                    vec_priority, 16'(vec_addr)};
            boot_pkg::OFS_DECODE: avs_readdata <= {15'h0000, first_fetch_addr};
            default:              avs_readdata <= '0;
         endcase
      end
   end

endmodule

// ---- boot_chk.sv ----
`timescale 1ns/1ps
module boot_chk
(
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic                  reset_pin_in,
   input wire logic                  reset_pin_oe,
   input wire logic                  width_select_pin,
   input wire boot_pkg::mem_req_type fetch_req,
   input wire logic                  fetch_ack,
   input wire logic                  boot_done,
   input wire logic [16:0]           first_fetch_addr,
   input wire logic                  ready_limit_hi,
   input wire logic                  ready_limit_lo,
   input wire logic                  bus_wide,
   input wire logic                  pd_request,
   input wire logic                  pd_grant,
   input wire logic [15:0]           irq_pending,
   input wire logic                  trap_opcode,
   input wire logic                  trap_software,
   input wire logic [16:0]           vec_addr,
   input wire logic                  vec_server,
   input wire logic [16:0]           decode_addr,
   input wire boot_pkg::region_type  decode_region,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic                  avs_waitrequest
);
   logic [4:0] rel_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // cycles since srst release, saturating
   always_ff @(posedge clk)
   begin
      if (srst)
         rel_cnt <= 5'h00;
      else if (rel_cnt != 5'h1f)
         rel_cnt <= rel_cnt + 5'h01;
   end

   a_pull_after_release: assert property (rel_cnt < 5'h10 |-> !reset_pin_oe)
      else $error("reset pin released too early");
   a_fetch_addr: assert property (fetch_req.req |-> fetch_req.addr == boot_pkg::SETUP_BYTE_ADDR)
      else $error("setup fetch at wrong address");
   a_fetch_holds: assert property (fetch_req.req && !fetch_ack |=> fetch_req.req)
      else $error("setup fetch dropped before answer");
   a_done_after_ack: assert property (fetch_req.req && fetch_ack |=> boot_done && !fetch_req.req)
      else $error("boot not done after setup answer");
   a_fetch_width: assert property ($stable(width_select_pin) [*5] ##0 fetch_req.req
      |-> fetch_req.wide == width_select_pin)
      else $error("setup fetch width differs from pin");
   a_setup_frozen: assert property ((boot_done && reset_pin_in) [*4] |=> $stable({ready_limit_hi, ready_limit_lo}))
      else $error("setup fields changed without reset");
   a_narrow_before_boot: assert property (!boot_done |-> !bus_wide)
      else $error("wide bus before setup loaded");
   a_pd_gate: assert property (pd_grant |-> boot_done && pd_request)
      else $error("power down granted without request");
   a_trap_first: assert property (trap_opcode |=> vec_addr == boot_pkg::TRAP_OPC_VEC && !vec_server)
      else $error("opcode trap vector wrong");
   a_nmi_vector: assert property (irq_pending[15] && !trap_opcode && !trap_software
      |=> vec_addr == 17'h0203e && !vec_server)
      else $error("nmi vector wrong");
   a_first_fetch: assert property (first_fetch_addr == boot_pkg::FIRST_FETCH_ADDR)
      else $error("first fetch address wrong");
   a_sfr_decode: assert property (decode_addr <= boot_pkg::SFR_LAST |=> decode_region == boot_pkg::REGION_SFR)
      else $error("sfr region decode wrong");
   a_bus_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait not one cycle");
endmodule

bind reset_config_and_vector_map boot_chk u_boot_chk
(
   .clk(clk), .srst(srst), .reset_pin_in(reset_pin_in), .reset_pin_oe(reset_pin_oe),
   .width_select_pin(width_select_pin), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
   .boot_done(boot_done), .first_fetch_addr(first_fetch_addr), .ready_limit_hi(ready_limit_hi),
   .ready_limit_lo(ready_limit_lo), .bus_wide(bus_wide), .pd_request(pd_request), .pd_grant(pd_grant),
   .irq_pending(irq_pending), .trap_opcode(trap_opcode), .trap_software(trap_software),
   .vec_addr(vec_addr), .vec_server(vec_server), .decode_addr(decode_addr),
   .decode_region(decode_region), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest)
);

// ---- boot_mem_model.sv ----
`timescale 1ns/1ps
module boot_mem_model
(
   input  wire logic                  clk,
   input  wire boot_pkg::mem_req_type fetch_req,
   input  wire logic [15:0]           setup_word,
   input  wire logic [3:0]            delay,
   output logic                       fetch_ack,
   output logic [15:0]                fetch_data
);
   logic [3:0]  wait_cnt = 4'h0;
   logic        ack_reg  = 1'b0;
   logic [15:0] churn    = 16'h5a5a;

   // answer a held request after a chosen number of cycles
   always_ff @(posedge clk)
   begin
      churn    <= churn + 16'h9e37;
      wait_cnt <= (fetch_req.req && !ack_reg) ? wait_cnt + 4'h1 : 4'h0;
      ack_reg  <= fetch_req.req && !ack_reg && wait_cnt == delay;
   end

   assign fetch_ack  = ack_reg;
   // undriven byte lanes churn every cycle
   assign fetch_data = ack_reg ? {(fetch_req.wide ? setup_word[15:8] : churn[15:8]), setup_word[7:0]} : churn;
endmodule

// ---- reset_config_and_vector_map_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module reset_config_and_vector_map_test;
   logic                  clk, srst, pin_low, width_pin, pd_request, topc, tsw, boot_done, bus_wide, pd_grant;
   logic                  vec_valid, vec_server, oe, fetch_ack, rl_hi, rl_lo, adv, split, avs_read, avs_write;
   logic                  avs_wait, reset_level, pin_out;
   logic [15:0]           fetch_data, pend, srv, mem_word;
   logic [16:0]           ffa, vec_addr, dec_addr, exp_a;
   logic [3:0]            avs_address, vec_prio, mem_delay;
   logic [31:0]           avs_wdata, avs_rdata, rd;
   logic [7:0]            bytes [4] = '{8'hc0, 8'h3f, 8'h15, 8'h2a};
   logic [16:0]           dec_in [8] = '{17'h0, 17'h19, 17'h1a, 17'h3ff, 17'h400, 17'h2018, 17'h2080, 17'hffff};
   logic [1:0]            dec_exp [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2};
   boot_pkg::mem_req_type fetch_req, seen_req;
   boot_pkg::region_type  region;
   int                    failures, checks_done, cycles;

   // open drain with pull-up, wired with the external driver
   assign reset_level = ((oe === 1'b0) ? pin_out : 1'b1) & !pin_low;

   reset_config_and_vector_map u_reset_config_and_vector_map
   (
      .clk(clk), .srst(srst), .reset_pin_in(reset_level), .reset_pin_out(pin_out), .reset_pin_oe(oe),
      .width_select_pin(width_pin), .fetch_req(fetch_req), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
      .boot_done(boot_done), .first_fetch_addr(ffa), .ready_limit_hi(rl_hi), .ready_limit_lo(rl_lo),
      .addr_strobe_is_valid(adv), .split_write_strobes(split), .bus_wide(bus_wide), .pd_request(pd_request),
      .pd_grant(pd_grant), .irq_pending(pend), .irq_to_server(srv), .trap_opcode(topc), .trap_software(tsw),
      .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_server(vec_server), .vec_priority(vec_prio),
      .decode_addr(dec_addr), .decode_region(region), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_wdata), .avs_byteenable(4'hf), .avs_readdata(avs_rdata),
      .avs_waitrequest(avs_wait)
   );

   boot_mem_model u_boot_mem_model
   (
      .clk(clk), .fetch_req(fetch_req), .setup_word(mem_word), .delay(mem_delay),
      .fetch_ack(fetch_ack), .fetch_data(fetch_data)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   always @(posedge clk)
   begin
      cycles++;
      if (fetch_req.req === 1'b1)
         seen_req <= fetch_req;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end

   task conclude();
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      avs_address <= a;
      avs_wdata   <= wd;
      avs_write   <= wr;
      avs_read    <= !wr;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_wait !== 1'b0);
      `CHK("wait cycles", 2, n)
      rd = avs_rdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task pull_check();
      int n;
      n = 0;
      repeat (40)
      begin
         @(posedge clk);
         n += (oe === 1'b0);
      end
      `CHK("pull length", 16, n)
      `CHK("pin drive", 1'b0, pin_out)
   endtask

   task vec(input logic [15:0] p, s, input logic o, t, input logic [16:0] ea, input logic es);
      pend <= p;
      srv  <= s;
      topc <= o;
      tsw  <= t;
      repeat (2) @(posedge clk);
      `CHK("vector valid", 1'b1, vec_valid)
      `CHK("vector addr", ea, vec_addr)
      `CHK("vector server", es, vec_server)
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial
   begin
      {srst, pin_low, width_pin} = 3'b111;
      {pd_request, topc, tsw, avs_read, avs_write} = 5'b0;
      {pend, srv, dec_addr, avs_address, avs_wdata, mem_word, mem_delay} = '0;
      {failures, checks_done, cycles} = '0;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         mem_word  <= {~bytes[i], bytes[i]};
         mem_delay <= 4'(i * 3);
         width_pin <= i[0] ? 1'b0 : 1'b1;
         seen_req  <= '0;
         srst      <= 1'b1;
         pin_low   <= 1'b1;
         repeat (16) @(posedge clk);
         pin_low <= 1'b0;
         repeat (4) @(posedge clk);
         srst <= 1'b0;
         pull_check();
         `CHK("boot done", 1'b1, boot_done)
         `CHK("fetch addr", boot_pkg::SETUP_BYTE_ADDR, seen_req.addr)
         `CHK("fetch width", !i[0], seen_req.wide)
         `CHK("ready mode", bytes[i][5:4], {rl_hi, rl_lo})
         `CHK("strobe style", bytes[i][3:2], {adv, split})
         `CHK("bus width", bytes[i][1] & !i[0], bus_wide)
         width_pin <= i[0];
         repeat (6) @(posedge clk);
         `CHK("bus width", bytes[i][1] & i[0], bus_wide)
         pd_request <= 1'b1;
         @(posedge clk);
         `CHK("power down", bytes[i][0], pd_grant)
         pd_request <= 1'b0;
         bus(1'b0, 4'h0, 32'h0);
         `CHK("setup reg", {24'h0, bytes[i]}, rd)
         bus(1'b1, 4'h0, 32'hffffffff);
         bus(1'b0, 4'h0, 32'h0);
         `CHK("setup reg", {24'h0, bytes[i]}, rd)
      end
      mem_word <= 16'h0011;
      pin_low  <= 1'b1;
      // pin filter needs two agreeing samples
      repeat (2) @(posedge clk);
      pin_low <= 1'b0;
      pull_check();
      `CHK("reboot done", 1'b1, boot_done)
      bus(1'b0, 4'h0, 32'h0);
      `CHK("setup reg", 32'h11, rd)
      `CHK("first fetch", 17'h02080, ffa)
      bus(1'b0, 4'hc, 32'h0);
      `CHK("first fetch reg", 32'h02080, rd)
      bus(1'b0, 4'h2, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      for (int n = 0; n < 32; n++)
      begin
         exp_a = (n[4] && n < 31) ? 17'h02040 + 17'(2 * n[3:0]) :
                 n[3] ? 17'h02030 + 17'(2 * n[2:0]) : 17'h02000 + 17'(2 * n[2:0]);
         vec(16'h1 << n[3:0], n[4] ? 16'h1 << n[3:0] : 16'h0, 1'b0, 1'b0, exp_a, n[4] && n < 31);
         `CHK("priority", n[3:0], vec_prio)
      end
      vec(16'h0f01, 16'h0001, 1'b0, 1'b0, 17'h02040, 1'b1);
      vec(16'h8000, 16'h0, 1'b0, 1'b1, 17'h02010, 1'b0);
      vec(16'h8000, 16'h0, 1'b1, 1'b1, 17'h02012, 1'b0);
      vec(16'h00ff, 16'h0, 1'b0, 1'b0, 17'h0200e, 1'b0);
      bus(1'b0, 4'h8, 32'h0);
      `CHK("vector reg", {10'h0, 1'b1, 1'b0, 4'h7, 16'h200e}, rd)
      for (int i = 0; i < 8; i++)
      begin
         dec_addr <= dec_in[i];
         repeat (2) @(posedge clk);
         `CHK("region", dec_exp[i], region)
      end
      conclude();
   end
endmodule
